// [shared/clk_reset_pkg.sv]
// Constants and carrier types for the core clock and reset release block
package clk_reset_pkg;

  // ********************************
  // Register bus
  // ********************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] POWER_MGMT_CONTROL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] CLOCK_STATUS_OFFSET       = 8'h04;

  // ********************************
  // Field layout of power_mgmt_control
  // ********************************
  localparam int MULT_W = 6;
  localparam int MULT_LSB = 0;
  localparam int PDS_LSB = 6;
  localparam int IDIV_BIT = 8;

  // ********************************
  // Field layout of clock_status
  // ********************************
  localparam int ST_MULT_LSB = 0;
  localparam int ST_CODE_LSB = 6;
  localparam int ST_STATE_LSB = 8;
  localparam int ST_RESET_BIT = 10;
  localparam int ST_PERIPH_BIT = 11;

  // ********************************
  // Reset values
  // ********************************
  localparam logic [MULT_W-1:0] MULT_RESET = 6'h10;
  localparam logic [1:0]        PDS_RESET  = 2'h0;
  localparam logic              IDIV_RESET = 1'b0;

  // Strap code to multiplier; plain defaults
  localparam logic [MULT_W-1:0] STRAP_MULT_0 = 6'h06;
  localparam logic [MULT_W-1:0] STRAP_MULT_1 = 6'h20;
  localparam logic [MULT_W-1:0] STRAP_MULT_2 = 6'h08;
  localparam logic [MULT_W-1:0] STRAP_MULT_3 = 6'h10;

  // ********************************
  // Timing counts
  // ********************************
  localparam int RESET_HOLD_CYCLES = 4096;
  localparam int CORE_TAIL_CYCLES  = 2;
  localparam int HOLD_W = 13;

  // ********************************
  // Types
  // ********************************
  typedef enum logic [1:0]
  {
    ST_IN_RESET = 2'b00,
    ST_HOLD     = 2'b01,
    ST_TAIL     = 2'b10,
    ST_RUN      = 2'b11
  } release_state_e;

  typedef struct packed
  {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_s;

  typedef struct packed
  {
    logic       core_clock;
    logic       peripheral_clock;
    logic       core_rise;
  } clock_out_s;

endpackage

// [src/core_clock_divider.sv]
// Glitch-free post divider giving core and peripheral clocks
`timescale 1ns/1ns
`default_nettype none

module core_clock_divider
  import clk_reset_pkg::*;
(
  input  wire logic                     clk,        // Block clock
  input  wire logic                     reset_n,    // Synchronous reset, active low
  input  wire logic [1:0]               ratio_code, // 0..3 select ratio 1,2,4,8
  output var  clk_reset_pkg::clock_out_s clocks     // Generated clocks
);

  typedef struct packed
  {
    logic [3:0] cnt;
    logic [1:0] code;
    logic       core;
    logic       periph;
    logic       rise;
  } div_state_s;

  div_state_s state;
  div_state_s next_state;

  function automatic logic [3:0] half_period(input logic [1:0] code);
    half_period = 4'h1 << code;
  endfunction

  always_comb
  begin
    next_state = state;
    next_state.rise = 1'b0;
    if (state.cnt == half_period(state.code) - 4'h1)
    begin
      next_state.cnt = 4'h0;
      next_state.core = ~state.core;
      if (!state.core)
      begin
        next_state.rise = 1'b1;
        next_state.periph = ~state.periph;
      end
      else
      begin
        next_state.code = ratio_code;
      end
    end
    else
    begin
      next_state.cnt = state.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign clocks = '{core_clock: state.core, peripheral_clock: state.periph, core_rise: state.rise};

endmodule

`default_nettype wire

// [src/core_clock_reset.sv]
// Core clock control and core reset release block
`timescale 1ns/1ns
`default_nettype none

//
// Function
// - The oscillator ratio reported is two times the multiplier in use.
// - The core clock is the oscillator divided by two times a ratio of 1, 2, 4 or 8 chosen by software.
// - While the external reset is low the post divider ratio is forced to one.
// - In reset the multiplier follows the straps, afterwards the value software writes.
// - With the input divider enabled the PLL reference runs at half the input clock.
// - The peripheral clock runs at half the core clock.
// - Core reset stays asserted for 4096 input clock cycles and two core clock cycles after external release.
// - A missed synchronising edge adds at most one input cycle, so the tail starts no later than 4100 input cycles after release.
module core_clock_reset
  import clk_reset_pkg::*;
#(
  parameter int HOLD_CYCLES = RESET_HOLD_CYCLES,
  parameter int TAIL_CYCLES = CORE_TAIL_CYCLES
)
(
  input  wire logic                      clk,               // Input clock, 100 MHz
  input  wire logic                      reset_n,           // Synchronous reset, active low
  input  wire logic                      ext_reset_n,       // Reset pin, asynchronous
  input  wire logic [1:0]                clock_ratio_straps,// Strap pins, asynchronous
  input  wire clk_reset_pkg::bus_req_s   bus_req,           // Register request
  output logic [DATA_W-1:0]              rdata,             // Read data, one cycle later
  output logic                           core_reset_n,      // Core reset, active low
  output logic [MULT_W:0]                oscillator_ratio,  // Two times multiplier
  output logic                           pll_ref_tick,      // PLL reference pulse
  output logic                           core_clock,        // Core clock
  output logic                           peripheral_clock   // Peripheral clock
);

  // ********************************
  // State
  // ********************************
  typedef struct packed
  {
    release_state_e    fsm;
    logic [HOLD_W-1:0] hold_cnt;
    logic [1:0]        tail_cnt;
    logic              rst_meta;
    logic              rst_sync;
    logic [1:0]        strap_meta;
    logic [1:0]        strap_sync;
    logic [MULT_W-1:0] mult;
    logic [1:0]        pds;
    logic              idiv;
    logic [1:0]        ratio_code;
    logic [MULT_W:0]   osc_ratio;
    logic              ref_phase;
    logic              ref_tick;
    logic              core_rst_n;
    logic [DATA_W-1:0] rdata;
  } blk_state_s;

  blk_state_s state;
  blk_state_s next_state;
  clock_out_s clocks;

  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYCLES - 1);
  localparam logic [1:0]        TAIL_LAST = 2'(TAIL_CYCLES - 1);

  function automatic logic [MULT_W-1:0] strap_mult(input logic [1:0] code);
    case (code)
      2'h0:    strap_mult = STRAP_MULT_0;
      2'h1:    strap_mult = STRAP_MULT_1;
      2'h2:    strap_mult = STRAP_MULT_2;
      default: strap_mult = STRAP_MULT_3;
    endcase
  endfunction

  function automatic logic [DATA_W-1:0] read_value(input blk_state_s s, input logic periph,
                                                   input logic [ADDR_W-1:0] addr);
    read_value = '0;
    if (addr == POWER_MGMT_CONTROL_OFFSET)
    begin
      read_value[MULT_LSB +: MULT_W] = s.mult;
      read_value[PDS_LSB +: 2] = s.pds;
      read_value[IDIV_BIT] = s.idiv;
    end
    else if (addr == CLOCK_STATUS_OFFSET)
    begin
      read_value[ST_MULT_LSB +: MULT_W] = s.osc_ratio[MULT_W:1];
      read_value[ST_CODE_LSB +: 2] = s.ratio_code;
      read_value[ST_STATE_LSB +: 2] = s.fsm;
      read_value[ST_RESET_BIT] = s.core_rst_n;
      read_value[ST_PERIPH_BIT] = periph;
    end
  endfunction

  // ********************************
  // Next state
  // ********************************
  always_comb
  begin
    next_state = state;
    next_state.rst_meta = ext_reset_n;
    next_state.rst_sync = state.rst_meta;
    next_state.strap_meta = clock_ratio_straps;
    next_state.strap_sync = state.strap_meta;
    next_state.rdata = '0;

    // Software writes, ignored while the pin holds reset
    if (bus_req.wr && state.rst_sync && bus_req.addr == POWER_MGMT_CONTROL_OFFSET)
    begin
      next_state.mult = bus_req.wdata[MULT_LSB +: MULT_W];
      next_state.pds = bus_req.wdata[PDS_LSB +: 2];
      next_state.idiv = bus_req.wdata[IDIV_BIT];
    end
    if (bus_req.rd)
    begin
      next_state.rdata = read_value(state, clocks.peripheral_clock, bus_req.addr);
    end

    if (!state.rst_sync)
    begin
      next_state.mult = strap_mult(state.strap_sync);
      next_state.pds = PDS_RESET;
      next_state.idiv = IDIV_RESET;
      next_state.ratio_code = 2'h0;
      next_state.fsm = ST_IN_RESET;
      next_state.hold_cnt = '0;
      next_state.tail_cnt = '0;
      next_state.core_rst_n = 1'b0;
    end
    else
    begin
      next_state.ratio_code = state.pds;
      case (state.fsm)
        ST_IN_RESET:
        begin
          next_state.fsm = ST_HOLD;
        end
        ST_HOLD:
        begin
          if (state.hold_cnt == HOLD_LAST)
          begin
            next_state.fsm = ST_TAIL;
          end
          else
          begin
            next_state.hold_cnt = state.hold_cnt + HOLD_W'(1);
          end
        end
        ST_TAIL:
        begin
          if (clocks.core_rise)
          begin
            if (state.tail_cnt == TAIL_LAST)
            begin
              next_state.fsm = ST_RUN;
              next_state.core_rst_n = 1'b1;
            end
            else
            begin
              next_state.tail_cnt = state.tail_cnt + 2'h1;
            end
          end
        end
        ST_RUN:
        begin
          next_state.core_rst_n = 1'b1;
        end
        default:
        begin
          next_state.fsm = ST_IN_RESET;
        end
      endcase
    end

    next_state.osc_ratio = {next_state.mult, 1'b0};

    next_state.ref_phase = state.idiv ? ~state.ref_phase : 1'b0;
    next_state.ref_tick = state.idiv ? ~state.ref_phase : 1'b1;
  end

  // ********************************
  // Registers
  // ********************************
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state <= '0;
      state.mult <= MULT_RESET;
      state.pds <= PDS_RESET;
      state.idiv <= IDIV_RESET;
      state.osc_ratio <= {MULT_RESET, 1'b0};
    end
    else
    begin
      state <= next_state;
    end
  end

  // ********************************
  // Post divider
  // ********************************
  // Ratio changes are latched inside at a period end only
  core_clock_divider u_divider
  (
    .clk        (clk),
    .reset_n    (reset_n),
    .ratio_code (state.ratio_code),
    .clocks     (clocks)
  );

  assign rdata = state.rdata;
  assign core_reset_n = state.core_rst_n;
  assign oscillator_ratio = state.osc_ratio;
  assign pll_ref_tick = state.ref_tick;
  assign core_clock = clocks.core_clock;
  assign peripheral_clock = clocks.peripheral_clock;

endmodule

`default_nettype wire

// [tb/core_clock_reset_chk.sv]
// Checker for the core clock and reset release block
`timescale 1ns/1ns
`default_nettype none

module core_clock_reset_chk
  import clk_reset_pkg::*;
#(
  parameter int HOLD_CYCLES = RESET_HOLD_CYCLES,
  parameter int TAIL_CYCLES = CORE_TAIL_CYCLES
)
(
  input wire logic                    clk,                // Input clock
  input wire logic                    reset_n,            // Sync reset
  input wire logic                    ext_reset_n,        // Reset pin
  input wire logic [1:0]              clock_ratio_straps, // Strap pins
  input wire clk_reset_pkg::bus_req_s bus_req,            // Register request
  input wire logic [DATA_W-1:0]       rdata,              // Read data
  input wire logic                    core_reset_n,       // Core reset
  input wire logic [MULT_W:0]         oscillator_ratio,   // Two times multiplier
  input wire logic                    pll_ref_tick,       // Reference pulse
  input wire logic                    core_clock,         // Core clock
  input wire logic                    peripheral_clock    // Peripheral clock
);
  // ****************************************
  // Helper counters
  // ****************************************
  // Worst tail: two rises at the slowest ratio
  localparam int LATE = HOLD_CYCLES + 8 + 16 * TAIL_CYCLES;
  localparam logic [MULT_W-1:0] SMULT [4] = '{STRAP_MULT_0, STRAP_MULT_1, STRAP_MULT_2, STRAP_MULT_3};
  int up_cnt;
  int hi_len;

  always_ff @(posedge clk)
  begin
    up_cnt <= (!reset_n || !ext_reset_n) ? 0 : up_cnt + 1;
    hi_len <= (!reset_n || !core_clock) ? 0 : hi_len + 1;
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Slowest ratio needs a full period plus sync before the forced ratio shows
  sequence ext_held;
    (!ext_reset_n)[*8] ##1 (!ext_reset_n)[*8] ##1 (!ext_reset_n)[*8] ##1 (!ext_reset_n)[*8];
  endsequence
  sequence strap_steady;
    (!ext_reset_n && $stable(clock_ratio_straps))[*6];
  endsequence

  forced_ratio_a: assert property (ext_held |-> core_clock != $past(core_clock))
    else $error("core clock not toggling while held in reset");
  strap_mult_a: assert property (strap_steady |-> oscillator_ratio == {SMULT[clock_ratio_straps], 1'b0})
    else $error("oscillator ratio does not follow the straps");
  early_release_a: assert property ($rose(core_reset_n) |-> up_cnt >= HOLD_CYCLES + 2 * TAIL_CYCLES)
    else $error("core reset released too early");
  late_release_a: assert property (up_cnt == LATE |-> core_reset_n)
    else $error("core reset released too late");
  reset_drop_a: assert property ($fell(ext_reset_n) |-> ##[1:4] !core_reset_n)
    else $error("core reset not asserted after pin low");
  ref_tick_a: assert property ($fell(pll_ref_tick) |=> pll_ref_tick)
    else $error("reference tick low for two cycles");
  high_width_a: assert property ($fell(core_clock) |-> hi_len inside {1, 2, 4, 8})
    else $error("core clock high phase of illegal length");
  periph_follow_a: assert property ($changed(peripheral_clock) |-> $rose(core_clock))
    else $error("peripheral clock moved off a core rise");
  rdata_idle_a: assert property (!$past(bus_req.rd) |-> rdata == '0)
    else $error("read data outside the answer cycle");
endmodule

bind core_clock_reset core_clock_reset_chk #(.HOLD_CYCLES(HOLD_CYCLES), .TAIL_CYCLES(TAIL_CYCLES)) core_clock_reset_chk_i
(
  .clk(clk), .reset_n(reset_n), .ext_reset_n(ext_reset_n), .clock_ratio_straps(clock_ratio_straps),
  .bus_req(bus_req), .rdata(rdata), .core_reset_n(core_reset_n), .oscillator_ratio(oscillator_ratio),
  .pll_ref_tick(pll_ref_tick), .core_clock(core_clock), .peripheral_clock(peripheral_clock)
);

`default_nettype wire

// [tb/strap_reset_source.sv]
// Model of the reset pin and strap source
`timescale 1ns/1ns
`default_nettype none

module strap_reset_source
#(
  parameter int LOCK_CYCLES  = 10000, // 100 us at 100 MHz
  parameter int SETUP_CYCLES = 2000,  // 20 us at 100 MHz
  parameter int LOW_MIN      = 4
)
(
  input  wire logic       clk,         // Input clock
  output var  logic       ext_reset_n, // Reset pin
  output var  logic [1:0] straps       // Strap pins
);
  bit powered;

  initial
  begin
    ext_reset_n = 1'b0;
    straps = 2'h0;
    powered = 1'b0;
  end

  task automatic set_straps(input logic [1:0] code);
    @(posedge clk);
    straps <= code;
  endtask

  task automatic hold_low(input int n);
    @(posedge clk);
    ext_reset_n <= 1'b0;
    repeat ((n < LOW_MIN) ? LOW_MIN : n) @(posedge clk);
  endtask

  task automatic release_pin();
    repeat (powered ? SETUP_CYCLES : LOCK_CYCLES) @(posedge clk);
    powered = 1'b1;
    ext_reset_n <= 1'b1;
  endtask
endmodule

`default_nettype wire

// [tb/core_clock_reset_tb.sv]
// Self-checking bench for the core clock and reset release block
`timescale 1ns/1ns
`default_nettype none

module core_clock_reset_tb;
  import clk_reset_pkg::*;
  localparam int HOLD = 8;
  localparam logic [MULT_W-1:0] SMULT [4] = '{STRAP_MULT_0, STRAP_MULT_1, STRAP_MULT_2, STRAP_MULT_3};
  logic              clk;
  logic              reset_n;
  logic              ext_reset_n;
  logic [1:0]        straps;
  bus_req_s          bus_req;
  logic [DATA_W-1:0] rdata;
  logic              core_reset_n;
  logic [MULT_W:0]   osc;
  logic              tick;
  logic              core_clock;
  logic              peripheral_clock;
  logic [DATA_W-1:0] got;
  int                num_errors;
  int                comparisons;
  int                n;

  core_clock_reset #(.HOLD_CYCLES(HOLD), .TAIL_CYCLES(CORE_TAIL_CYCLES)) core_clock_reset_i
  (
    .clk(clk), .reset_n(reset_n), .ext_reset_n(ext_reset_n), .clock_ratio_straps(straps), .bus_req(bus_req),
    .rdata(rdata), .core_reset_n(core_reset_n), .oscillator_ratio(osc), .pll_ref_tick(tick),
    .core_clock(core_clock), .peripheral_clock(peripheral_clock)
  );
  strap_reset_source strap_reset_source_i (.clk(clk), .ext_reset_n(ext_reset_n), .straps(straps));

  always #5 clk = ~clk;

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1 d = rdata;
  endtask

  // Cycles between two rises of core or peripheral clock
  task automatic gap(input bit per, output int gp);
    logic prev;
    logic cur;
    int   first;
    prev = 1'b1;
    first = -1;
    gp = 0;
    for (int k = 0; k < 80 && gp == 0; k++)
    begin
      @(posedge clk);
      #1 cur = per ? peripheral_clock : core_clock;
      if (cur === 1'b1 && prev === 1'b0)
      begin
        if (first >= 0)
          gp = k - first;
        first = k;
      end
      prev = cur;
    end
  endtask

  task automatic wait_release(output int k);
    k = 0;
    while (core_reset_n !== 1'b1 && k < HOLD + 60)
    begin
      @(posedge clk);
      #1 k++;
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_straps();
    for (int c = 0; c < 4; c++)
    begin
      strap_reset_source_i.set_straps(c[1:0]);
      repeat (6) @(posedge clk);
      #1 check(32'(osc), 32'({SMULT[c], 1'b0}));
      rd(POWER_MGMT_CONTROL_OFFSET, got);
      check(got, {26'h0, SMULT[c]});
    end
    // Writes are refused while the pin holds reset
    wr(POWER_MGMT_CONTROL_OFFSET, 32'h3);
    rd(POWER_MGMT_CONTROL_OFFSET, got);
    check(got, {26'h0, SMULT[3]});
    $display("test straps done");
  endtask

  task automatic t_release();
    strap_reset_source_i.release_pin();
    wait_release(n);
    check(32'(n >= HOLD + 4 && n <= HOLD + 10), 32'h1);
    rd(CLOCK_STATUS_OFFSET, got);
    check(32'(got[10:8]), 32'h7);
    $display("test release done");
  endtask

  task automatic t_ratio();
    for (int c = 0; c < 4; c++)
    begin
      wr(POWER_MGMT_CONTROL_OFFSET, 32'h3 | (c << 6));
      repeat (20) @(posedge clk);
      #1 check(32'(osc), 32'h6);
      gap(1'b0, n);
      check(n, 2 << c);
      gap(1'b1, n);
      check(n, 4 << c);
      rd(CLOCK_STATUS_OFFSET, got);
      check(32'(got[7:0]), 32'h3 | (c << 6));
    end
    $display("test ratio done");
  endtask

  task automatic t_idiv();
    logic a;
    wr(POWER_MGMT_CONTROL_OFFSET, 32'h103);
    repeat (4) @(posedge clk);
    #1 a = tick;
    @(posedge clk);
    #1 check(32'(a ^ tick), 32'h1);
    wr(POWER_MGMT_CONTROL_OFFSET, 32'h3);
    repeat (4) @(posedge clk);
    #1 check(32'(tick), 32'h1);
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, got);
    check(got, 32'h0);
    rd(POWER_MGMT_CONTROL_OFFSET, got);
    check(got, 32'h3);
    @(posedge clk);
    #1 check(rdata, 32'h0);
    $display("test divider and map done");
  endtask

  task automatic t_rereset();
    wr(POWER_MGMT_CONTROL_OFFSET, 32'hc3);
    fork
      strap_reset_source_i.hold_low(60);
      begin
        repeat (30) @(posedge clk);
        #1 check(32'(core_reset_n), 32'h0);
        gap(1'b0, n);
        check(n, 2);
        check(32'(osc), 32'({SMULT[3], 1'b0}));
      end
    join
    strap_reset_source_i.release_pin();
    wait_release(n);
    check(32'(core_reset_n), 32'h1);
    $display("test second reset done");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    reset_n = 1'b0;
    bus_req = '0;
    num_errors = 0;
    comparisons = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_straps();
    t_release();
    t_ratio();
    t_idiv();
    t_rereset();
    conclude();
  end

  // Whole run is near 12500 cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    num_errors++;
    conclude();
  end
endmodule

`default_nettype wire
